/* hdl/smsp_top.sv */
// Purpose: four-line synchronous serial port, master or slave, byte wide
// Assumes: ref_clk well above the link clock; link pins sampled through two flops
// Notes: the data pin input is never driven; slave select is only ever an input
//
// Behaviour
// - Slave select released mid-byte sets incomplete and done flags together.
// - Software writing the incomplete flag does not set the done flag.
// - Incomplete detection happens only in slave mode.
// - Clock idles high when idle-level bit is 0, low when 1.
// - Capture edge follows the idle level and edge select bit.
// - Bit order select 1 shifts MSB first, 0 LSB first.
// - Select pin ignored when its enable is 0, active select when 1.
// - Data write during a transfer is dropped and sets the collision flag.
// - Done flag set at each byte end; only software clears it.
// - Master: data write starts the clock and full-duplex shifting.
// - Slave: external clock shifts data out and in.
// - Port keeps working while its clock source runs.
// - Enabled idle: master data out high, master clock at idle level; a selected slave drives its current tx_shift bit.
// - Slave never drives the clock line.
// - Port disabled releases all serial lines.
// - Received bits reach the data register only after a whole byte.
// - Upper two bits of control register b read as zero.
// - Role field picks master clock source or slave; 110 and 111 unused.
`timescale 1ns/100ps
`include "smsp_regs.svh"

module smsp_top
   import smsp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic serial_clock_line_in,
   input wire logic serial_data_in,
   input wire logic slave_select_n,
   input wire logic sub_clock_in,
   input wire logic timer_match,
   output smsp_pins_t link_out
);

   function automatic logic role_is_master(input logic [2:0] code);
      role_is_master = (code <= `SMSP_ROLE_TIMER);
   endfunction : role_is_master

   logic [2:0] role_clock_select;
   logic serial_port_enable;
   logic slave_incomplete_flag;
   logic clock_idle_level_select;
   logic clock_edge_select;
   logic bit_order_select;
   logic select_pin_enable;
   logic write_collision_flag;
   logic transfer_done_flag;
   logic [7:0] shift_data_register;
   logic [7:0] tx_shift;
   logic [7:0] rx_buf;
   logic [3:0] bit_cnt;
   logic [4:0] edge_cnt;
   logic [4:0] div_cnt;
   logic sck_lvl;
   smsp_state_t state;
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic [3:0] sync3;

   // Sync slots: 0 clock, 1 data in, 2 select, 3 sub clock
   logic [3:0] pin_raw;
   assign pin_raw = {sub_clock_in, slave_select_n, serial_data_in, serial_clock_line_in};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               sync1[gi] <= 1'b0;
               sync2[gi] <= 1'b0;
               sync3[gi] <= 1'b0;
            end else begin
               sync1[gi] <= pin_raw[gi];
               sync2[gi] <= sync1[gi];
               sync3[gi] <= sync2[gi];
            end
         end
      end
   endgenerate

   logic is_master;
   logic is_slave;
   logic idle_lvl;
   logic sel_active;
   logic busy;
   logic wr_ctrl_a;
   logic wr_ctrl_b;
   logic wr_data;
   logic half_tick;
   logic [4:0] half_len;
   logic ev_edge;
   logic ev_lead;
   logic cap;
   logic launch;
   logic last_cap;
   logic finish;
   logic abort_sel;
   logic start;
   logic cur_bit;
   logic [2:0] cap_pipe;
   logic [2:0] last_pipe;
   logic [2:0] end_pipe;
   logic rx_take;
   logic rx_last;

   assign is_master = serial_port_enable && role_is_master(role_clock_select);
   assign is_slave = serial_port_enable && (role_clock_select == `SMSP_ROLE_SLAVE);
   assign idle_lvl = ~clock_idle_level_select;
   assign sel_active = !select_pin_enable || !sync2[2];
   assign busy = (state == SMSP_SHIFT);
   assign wr_ctrl_a = reg_wr && (reg_addr == `SMSP_OFS_CTRL_A);
   assign wr_ctrl_b = reg_wr && (reg_addr == `SMSP_OFS_CTRL_B);
   assign wr_data = reg_wr && (reg_addr == `SMSP_OFS_DATA);

   always_comb begin
      case (role_clock_select)
         `SMSP_ROLE_DIV4: half_len = `SMSP_HALF_DIV4;
         `SMSP_ROLE_DIV16: half_len = `SMSP_HALF_DIV16;
         default: half_len = `SMSP_HALF_DIV64;
      endcase
   end

   // Each tick is half a master clock period
   always_comb begin
      case (role_clock_select)
         `SMSP_ROLE_SUB: half_tick = (sync2[3] != sync3[3]);
         `SMSP_ROLE_TIMER: half_tick = timer_match; // Toggle per match gives match rate / 2
         default: half_tick = (div_cnt == half_len - 5'h01);
      endcase
   end

   // Master edges come from the tick, slave edges from the sampled pin
   always_comb begin
      if (is_master) begin
         // No further edges once the frame's sixteen are out; the tail only waits for data
         ev_edge = busy && half_tick && (edge_cnt != `SMSP_EDGES);
         ev_lead = !edge_cnt[0];
      end else begin
         // An idle slave opens a byte only on a leading edge, so the trailing edge
         // that closes a byte cannot start a phantom one
         ev_edge = is_slave && sel_active && (sync2[0] != sync3[0])
                   && (busy || (sync2[0] != idle_lvl));
         ev_lead = (sync2[0] != idle_lvl);
      end
   end

   // Edge select 0 captures on the trailing edge, 1 on the leading edge
   assign cap = ev_edge && (clock_edge_select ? ev_lead : !ev_lead);
   assign launch = ev_edge && !cap && (bit_cnt != 4'h0) && (bit_cnt < `SMSP_BITS);
   assign last_cap = cap && (bit_cnt == `SMSP_BITS - 4'h1);
   // The master ends three cycles after its last edge, once the last bit is in
   assign finish = is_master ? end_pipe[2] : last_cap;
   // Master input data return through the output flop and the two-flop synchroniser,
   // so they are taken three cycles after the master's own capture edge
   assign rx_take = is_master ? cap_pipe[2] : cap;
   assign rx_last = is_master ? last_pipe[2] : last_cap;
   assign abort_sel = is_slave && select_pin_enable && busy
                      && sync2[2] && !sync3[2];
   assign start = wr_data && is_master && !busy;
   assign cur_bit = bit_order_select ? tx_shift[7] : tx_shift[0];

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= SMSP_IDLE;
      end else if (!serial_port_enable || abort_sel || finish) begin
         state <= SMSP_IDLE;
      end else if (start) begin
         state <= SMSP_SHIFT;
      end else if (is_slave && ev_edge && !busy) begin
         state <= SMSP_SHIFT;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         div_cnt <= 5'h00;
      end else if (!busy || half_tick) begin
         div_cnt <= 5'h00;
      end else begin
         div_cnt <= div_cnt + 5'h01;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         edge_cnt <= 5'h00;
         sck_lvl <= 1'b1;
      end else if (!busy || !is_master) begin
         edge_cnt <= 5'h00;
         sck_lvl <= idle_lvl;
      end else if (ev_edge) begin
         edge_cnt <= edge_cnt + 5'h01;
         sck_lvl <= ~sck_lvl;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         bit_cnt <= 4'h0;
      end else if (!serial_port_enable || abort_sel || finish || start) begin
         bit_cnt <= 4'h0;
      end else if (cap) begin
         bit_cnt <= bit_cnt + 4'h1;
      end
   end

   // Cleared whenever the master role goes away, so a disable never sets a flag late
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cap_pipe <= 3'h0;
         last_pipe <= 3'h0;
         end_pipe <= 3'h0;
      end else if (!is_master) begin
         cap_pipe <= 3'h0;
         last_pipe <= 3'h0;
         end_pipe <= 3'h0;
      end else begin
         cap_pipe <= {cap_pipe[1:0], cap};
         last_pipe <= {last_pipe[1:0], last_cap};
         end_pipe <= {end_pipe[1:0], ev_edge && (edge_cnt == `SMSP_EDGES - 5'h01)};
      end
   end

   // Collected bits stay internal until the byte is complete
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_buf <= 8'h00;
      end else if (rx_take && bit_order_select) begin
         rx_buf <= {rx_buf[6:0], sync2[1]};
      end else if (rx_take) begin
         rx_buf <= {sync2[1], rx_buf[7:1]};
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         shift_data_register <= 8'h00;
      end else if (rx_last && bit_order_select) begin
         shift_data_register <= {rx_buf[6:0], sync2[1]};
      end else if (rx_last) begin
         shift_data_register <= {sync2[1], rx_buf[7:1]};
      end
   end

   // A write while busy never touches the byte on the wire
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_shift <= 8'hff;
      end else if (wr_data && !busy) begin
         tx_shift <= reg_wdata;
      end else if (launch && bit_order_select) begin
         tx_shift <= {tx_shift[6:0], 1'b1};
      end else if (launch) begin
         tx_shift <= {1'b1, tx_shift[7:1]};
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         role_clock_select <= 3'(`SMSP_A_RESET >> `SMSP_A_ROLE_LO);
         serial_port_enable <= 1'b0;
      end else if (wr_ctrl_a) begin
         role_clock_select <= reg_wdata[`SMSP_A_ROLE_HI:`SMSP_A_ROLE_LO];
         serial_port_enable <= reg_wdata[`SMSP_A_ENABLE];
      end
   end

   // Hardware set wins over a software clear in the same cycle
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         slave_incomplete_flag <= 1'b0;
      end else if (abort_sel) begin
         slave_incomplete_flag <= 1'b1;
      end else if (wr_ctrl_a) begin
         slave_incomplete_flag <= reg_wdata[`SMSP_A_INCOMPLETE];
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         clock_idle_level_select <= 1'b0;
         clock_edge_select <= 1'b0;
         bit_order_select <= 1'b0;
         select_pin_enable <= 1'b0;
      end else if (wr_ctrl_b) begin
         clock_idle_level_select <= reg_wdata[`SMSP_B_IDLE_LEVEL];
         clock_edge_select <= reg_wdata[`SMSP_B_EDGE];
         bit_order_select <= reg_wdata[`SMSP_B_ORDER];
         select_pin_enable <= reg_wdata[`SMSP_B_SEL_EN];
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         write_collision_flag <= 1'b0;
      end else if (wr_data && busy) begin
         write_collision_flag <= 1'b1;
      end else if (wr_ctrl_b) begin
         write_collision_flag <= reg_wdata[`SMSP_B_COLLISION];
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         transfer_done_flag <= 1'b0;
      end else if (finish || abort_sel) begin
         transfer_done_flag <= 1'b1;
      end else if (wr_ctrl_b) begin
         transfer_done_flag <= reg_wdata[`SMSP_B_DONE];
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else if (!reg_rd) begin
         reg_rdata <= 8'h00;
      end else if (reg_addr == `SMSP_OFS_CTRL_A) begin
         reg_rdata <= {role_clock_select, 3'h0, serial_port_enable, slave_incomplete_flag};
      end else if (reg_addr == `SMSP_OFS_CTRL_B) begin
         reg_rdata <= {2'h0, clock_idle_level_select, clock_edge_select,
                       bit_order_select, select_pin_enable,
                       write_collision_flag, transfer_done_flag};
      end else if (reg_addr == `SMSP_OFS_DATA) begin
         reg_rdata <= shift_data_register;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // Disabled or unused role codes release every line
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         link_out <= '{sck_out: 1'b0, sck_oe: 1'b0, sdo_out: 1'b0, sdo_oe: 1'b0};
      end else begin
         link_out.sck_out <= is_master ? sck_lvl : 1'b0;
         link_out.sck_oe <= is_master;
         link_out.sdo_out <= (is_master ? busy : (is_slave && sel_active))
                             ? cur_bit : 1'b1;
         link_out.sdo_oe <= is_master || is_slave;
      end
   end

endmodule : smsp_top

/* hdl/smsp_regs.svh */
// Purpose: offsets, field positions, reset values and divider counts of the serial port
// Assumes: register index equals the address on the plain register port
// Notes: definitions only
`ifndef SMSP_REGS_SVH
`define SMSP_REGS_SVH

`define SMSP_OFS_CTRL_A 2'h0
`define SMSP_OFS_CTRL_B 2'h1
`define SMSP_OFS_DATA 2'h2

// serial_port_control_a fields
`define SMSP_A_ROLE_HI 7
`define SMSP_A_ROLE_LO 5
`define SMSP_A_ENABLE 1
`define SMSP_A_INCOMPLETE 0
`define SMSP_A_RESET 8'he0

// serial_port_control_b fields
`define SMSP_B_IDLE_LEVEL 5
`define SMSP_B_EDGE 4
`define SMSP_B_ORDER 3
`define SMSP_B_SEL_EN 2
`define SMSP_B_COLLISION 1
`define SMSP_B_DONE 0
`define SMSP_B_RESET 8'h00

// role_clock_select codes
`define SMSP_ROLE_DIV4 3'h0
`define SMSP_ROLE_DIV16 3'h1
`define SMSP_ROLE_DIV64 3'h2
`define SMSP_ROLE_SUB 3'h3
`define SMSP_ROLE_TIMER 3'h4
`define SMSP_ROLE_SLAVE 3'h5

// Half periods of the master clock in system clocks
`define SMSP_HALF_DIV4 5'h02
`define SMSP_HALF_DIV16 5'h08
`define SMSP_HALF_DIV64 5'h20

`define SMSP_BITS 4'h8
`define SMSP_EDGES 5'h10

`endif

/* hdl/smsp_pkg.sv */
// Purpose: types shared by the serial port and its bench
// Assumes: constants live in smsp_regs.svh
// Notes: none
package smsp_pkg;

   typedef enum logic {
      SMSP_IDLE,
      SMSP_SHIFT
   } smsp_state_t;

   // Driven side of the link pins
   typedef struct packed {
      logic sck_out;
      logic sck_oe;
      logic sdo_out;
      logic sdo_oe;
   } smsp_pins_t;

endpackage : smsp_pkg

/* testbench/smsp_sva.sv */
// Purpose: concurrent checks on the serial port pins and register port
// Assumes: control fields are shadowed here from register writes
// Notes: idle master means no clock change for more than 70 cycles and no data write for 63
`timescale 1ns/100ps
`include "smsp_regs.svh"
module smsp_sva
   import smsp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire smsp_pins_t link_out
);
   logic [2:0] role;
   logic en, idle_sel, last_sck, data_wr, settled;
   logic [6:0] quiet;
   logic [5:0] since_wr;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   assign data_wr = reg_wr && reg_addr == `SMSP_OFS_DATA;
   assign settled = quiet > 7'h46 && since_wr == 6'h3f && en && role < `SMSP_ROLE_SLAVE;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         role <= 3'h7;
         en <= 1'b0;
         idle_sel <= 1'b0;
      end else if (reg_wr && reg_addr == `SMSP_OFS_CTRL_A) begin
         role <= reg_wdata[7:5];
         en <= reg_wdata[1];
      end else if (reg_wr && reg_addr == `SMSP_OFS_CTRL_B) begin
         idle_sel <= reg_wdata[5];
      end
   end
   // Busy state is hidden, so clock activity is judged at the pin
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         last_sck <= 1'b0;
         quiet <= 7'h00;
         since_wr <= 6'h00;
      end else begin
         last_sck <= link_out.sck_out;
         quiet <= (link_out.sck_out != last_sck) ? 7'h00 : quiet + 7'(quiet != 7'h7f);
         since_wr <= data_wr ? 6'h00 : since_wr + 6'(since_wr != 6'h3f);
      end
   end
   sequence start_req;
      data_wr && settled;
   endsequence
   sequence clk_runs;
      ##[1:40] link_out.sck_out != last_sck;
   endsequence
   chk_start_clock: assert property (start_req |-> clk_runs)
      else $error("data write did not start the clock");
   chk_idle_level: assert property (settled && $past(link_out.sck_oe, 2)
      && idle_sel == $past(idle_sel, 3) |-> link_out.sck_out == !idle_sel)
      else $error("wrong clock idle level");
   chk_sdo_idle: assert property (settled && $past(link_out.sdo_oe, 2) |-> link_out.sdo_out)
      else $error("data out not high while idle");
   chk_sdo_drive: assert property (en && $past(en) && role <= `SMSP_ROLE_SLAVE
      && $stable(role) |-> link_out.sdo_oe)
      else $error("data out not driven while enabled");
   chk_slave_clock: assert property (role == `SMSP_ROLE_SLAVE && $stable(role)
      |-> !link_out.sck_oe)
      else $error("slave drives the clock");
   chk_off_release: assert property (!en && !$past(en)
      |-> !link_out.sck_oe && !link_out.sdo_oe)
      else $error("disabled port drives a line");
   chk_role_unused: assert property (role > `SMSP_ROLE_SLAVE && $stable(role)
      |-> !link_out.sck_oe && !link_out.sdo_oe)
      else $error("unused role drives a line");
   chk_ctlb_upper: assert property ($past(reg_rd) && $past(reg_addr) == `SMSP_OFS_CTRL_B
      |-> reg_rdata[7:6] == 2'h0)
      else $error("control b upper bits not zero");
endmodule : smsp_sva
bind smsp_top smsp_sva chk (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .link_out);

/* testbench/smsp_peer.sv */
// Purpose: far-side link device, slave or master to the port
// Assumes: its own clock has a half period of 80 ns
// Notes: data line inverts between frames rather than hold its last value
`timescale 1ns/100ps
module smsp_peer (
   input wire logic sck_w,
   input wire logic sdo_w,
   output logic sck_m,
   output logic sd_m,
   output logic sel_n
);
   initial {sck_m, sd_m, sel_n} = 3'h5;
   function automatic int pos(input int j, input bit msb);
      return msb ? 7 - j : j;
   endfunction : pos
   // Edge k captures on odd k when es is 1, on even k otherwise
   task automatic step(input int k, input logic [7:0] tx, input bit es, msb,
      inout logic [7:0] rx);
      if ((k % 2 == 1) == es) rx[pos((k - 1) / 2, msb)] = sdo_w;
      else if ((k - 1 + es) / 2 < 8) sd_m = tx[pos((k - 1 + es) / 2, msb)];
   endtask : step
   task automatic as_slave(input logic [7:0] tx, input bit es, msb, output logic [7:0] rx);
      sd_m = tx[pos(0, msb)];
      for (int k = 1; k <= 16; k++) begin
         @(sck_w);
         step(k, tx, es, msb, rx);
      end
      sd_m = ~sd_m;
   endtask : as_slave
   task automatic as_master(input logic [7:0] tx, input bit es, msb, sel, input int n,
      output logic [7:0] rx);
      #3 sel_n = !sel;
      sd_m = tx[pos(0, msb)];
      #240;
      for (int k = 1; k <= n; k++) begin
         sck_m = ~sck_m;
         step(k, tx, es, msb, rx);
         #80;
      end
      sel_n = 1'b1;
      sd_m = ~sd_m;
   endtask : as_master
   task automatic park(input bit il);
      sck_m = !il;
   endtask : park
endmodule : smsp_peer

/* testbench/testbench.sv */
// Purpose: self-checking bench of the serial port in both roles
// Assumes: the peer model stands on the far side of the link pins
// Notes: expected transmit bytes come from the bench's own queue, expected received bytes from ptx
`timescale 1ns/100ps
`include "smsp_regs.svh"
module testbench;
   import smsp_pkg::*;
   localparam logic [1:0] ofs_a = `SMSP_OFS_CTRL_A, ofs_b = `SMSP_OFS_CTRL_B;
   localparam logic [1:0] ofs_d = `SMSP_OFS_DATA;
   logic ref_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, d, ptx, prx, cb;
   logic sub_clock_in = 1'b0, timer_match = 1'b0, sck_m, sd_m, sel_n;
   logic [2:0] role;
   logic [7:0] exp_q[$];
   smsp_pins_t link_out;
   int errors = 0, samples_checked = 0, cycles = 0, seed = 40, i, n;
   wire logic sck_w = link_out.sck_oe ? link_out.sck_out : sck_m;
   smsp_top uut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .serial_clock_line_in(sck_w), .serial_data_in(sd_m), .slave_select_n(sel_n),
      .sub_clock_in(sub_clock_in), .timer_match(timer_match), .link_out(link_out));
   smsp_peer peer (.sck_w(sck_w), .sdo_w(link_out.sdo_out), .sck_m(sck_m), .sd_m(sd_m),
      .sel_n(sel_n));
   always #5 ref_clk = ~ref_clk;
   always #50 sub_clock_in = ~sub_clock_in;
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      timer_match <= (cycles % 4 == 0);
      if (cycles == 30000) begin
         errors++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checked %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   task automatic check(input logic [7:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rdc(input logic [1:0] a, input logic [7:0] e, input bit cmp = 1'b1);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      d = reg_rdata;
      if (cmp) check(d, e);
   endtask : rdc
   // Bounded poll; running out of polls counts as a mismatch
   task automatic wait_done();
      d = 8'h00;
      for (n = 0; n < 3000 && d[0] !== 1'b1; n++) rdc(ofs_b, 8'h00, 1'b0);
      check({7'h00, d[0]}, 8'h01);
   endtask : wait_done
   initial begin
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      rdc(ofs_a, `SMSP_A_RESET);
      rdc(ofs_b, `SMSP_B_RESET);
      rdc(2'h3, 8'h00);
      wr(ofs_b, 8'hc0);
      rdc(ofs_b, 8'h00);
      wr(ofs_a, 8'hde);
      rdc(ofs_a, 8'hc2);
      $display("test registers done");
      for (i = 0; i < 8; i++) begin
         role = 3'(i % 5);
         cb = {2'h0, i[2:0], 3'h0};
         wr(ofs_a, {role, 5'h00});
         wr(ofs_b, cb);
         wr(ofs_a, {role, 5'h02});
         ptx = 8'($random(seed));
         exp_q.push_back(8'($random(seed)));
         repeat (4) @(posedge ref_clk);
         fork
            peer.as_slave(ptx, cb[4], cb[3], prx);
            begin
               wr(ofs_d, exp_q[0]);
               repeat (8) @(posedge ref_clk);
               wr(ofs_d, ~exp_q[0]);
               wait_done();
            end
         join
         check(prx, exp_q.pop_front());
         rdc(ofs_d, ptx);
         rdc(ofs_b, cb | 8'h03);
         wr(ofs_b, cb);
         rdc(ofs_b, cb);
         rdc(ofs_a, {role, 5'h02});
         repeat (80) @(posedge ref_clk);
      end
      $display("test master done");
      for (i = 0; i < 4; i++) begin
         cb = {2'h0, i[1:0], 1'($random(seed)), i != 1, 2'h0};
         wr(ofs_a, 8'ha0);
         peer.park(cb[5]);
         wr(ofs_b, cb);
         wr(ofs_a, 8'ha2);
         ptx = 8'($random(seed));
         exp_q.push_back(8'($random(seed)));
         wr(ofs_d, exp_q[0]);
         peer.as_master(ptx, cb[4], cb[3], cb[2], 16, prx);
         wait_done();
         check(prx, exp_q.pop_front());
         rdc(ofs_d, ptx);
         rdc(ofs_a, 8'ha2);
         wr(ofs_b, cb);
      end
      peer.as_master(ptx, cb[4], cb[3], 1'b1, 6, prx);
      repeat (10) @(posedge ref_clk);
      rdc(ofs_a, 8'ha3);
      rdc(ofs_b, cb | 8'h01);
      wr(ofs_b, cb);
      wr(ofs_a, 8'ha2);
      wr(ofs_a, 8'ha3);
      rdc(ofs_b, cb);
      $display("test slave done");
      print_verdict();
   end
endmodule : testbench
